/* core/idc_core.sv */
// Device-side identification command engine on the taskfile registers
// Assumes the host writes a register with a one-cycle strobe and reads data with a one-cycle strobe
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Command code ech starts a device-to-host PIO data-in transfer.
// - Completion: BSY clear, DRDY set, DF, DRQ, ERR clear, select bit echoed.
// - Packet devices abort and load the packet signature into the command block.
// - Non-packet devices never report an error for this command.
// - Set BSY, prepare 256 words, set DRQ, clear BSY, interrupt unless disabled.
// - Reserved bits and words return zero.
// - A word's msb drives line 15 and lsb line 0.
// - 32-bit values go as two words, low half first.
// - Word 0: bit 15 zero, bit 7 removable, bit 2 incomplete.
// - Serial in words 10-19, firmware 23-26, model 27-46.
// - Word 47: 80h upper byte, max sectors per interrupt lower.
// - Word 49 reports standby timer, IORDY, IORDY disable, LBA, DMA.
// - Word 50: bit 15 zero, bit 14 one, bit 0 one.
// - Word 53 flags validity of words 64-70.
// - Word 59: bit 8 valid setting, low byte current sectors per interrupt.
// - Word 63 shows selected and supported multiword DMA modes.
// - Word 64 PIO modes; words 65-68 cycle times in nanoseconds.
// - Word 75 low five bits hold queue depth minus one.
// - Version words read 0000h when no version is reported.
// - Feature words: packet bit zero, 48-bit bit reported, bits 15/14 zero/one.
module idc_core
	import idc_pkg::*;
#(
	parameter logic        DEVICE_NUM  = 1'b0,
	parameter logic        PACKET_DEV  = 1'b0,
	parameter int          PREP_CYCLES = IDC_PREP_CYC,
	parameter logic [31:0] SECTORS     = 32'h0001_0000,
	parameter logic [7:0]  MULT_MAX    = 8'h10
)
(
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        cmd_wr,
	input  wire logic [7:0]  cmd_data,
	input  wire logic        sel_wr,
	input  wire logic [7:0]  sel_data,
	input  wire logic        irq_disable,
	input  wire logic        data_rd,
	input  wire logic        removable,
	input  wire logic        incomplete,
	input  wire logic        mult_valid,
	input  wire logic [7:0]  mult_cur,
	input  wire logic [2:0]  mdma_sel,
	input  wire logic [4:0]  queue_depth_m1,
	output logic      [15:0] data_out,
	output logic      [7:0]  status,
	output logic      [7:0]  drive_select,
	output logic      [7:0]  error_reg,
	output logic      [7:0]  sig_count,
	output logic      [7:0]  sig_lba_low,
	output logic      [7:0]  sig_lba_mid,
	output logic      [7:0]  sig_lba_high,
	output logic             intrq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	idc_state_t  state_q, state_d;
	logic [7:0]  idx_q, idx_d;
	logic [7:0]  stat_q, stat_d;
	logic [7:0]  sel_q, sel_d;
	logic [7:0]  err_q, err_d;
	logic [31:0] sig_q, sig_d;
	logic        irq_q, irq_d;
	logic [15:0] dout_q, dout_d;
	logic [15:0] rom_word;
	logic        prep_start;
	logic        prep_done;
	logic        addressed;
	logic        go;

	// The device only answers when its own number is selected
	assign addressed = (sel_q[IDC_DEV_BIT] == DEVICE_NUM);
	assign go = cmd_wr && cmd_data == IDC_CMD_IDENTIFY && addressed && state_q == IDC_IDLE;

	assign prep_start = go && !PACKET_DEV;

	idc_prep_timer #(
		.CYCLES (PREP_CYCLES)
	) u_timer (
		.mclk  (mclk),
		.reset (reset),
		.start (prep_start),
		.done  (prep_done)
	);

	// Next index is prefetched so data_out is a flop, not a decode path
	idc_word_rom u_rom (
		.index          (idx_d),
		.removable      (removable),
		.incomplete     (incomplete),
		.mult_max       (MULT_MAX),
		.mult_valid     (mult_valid),
		.mult_cur       (mult_cur),
		.sectors        (SECTORS),
		.mdma_sel       (mdma_sel),
		.queue_depth_m1 (queue_depth_m1),
		.word           (rom_word)
	);

	// ----------------------------------------
	// Command sequencing
	// ----------------------------------------
	always_comb
	begin
		state_d = state_q;
		idx_d   = idx_q;
		stat_d  = stat_q;
		sel_d   = sel_q;
		err_d   = err_q;
		sig_d   = sig_q;
		irq_d   = irq_q;
		dout_d  = dout_q;
		// Writes to the select register are ignored while busy
		if (sel_wr && !stat_q[IDC_ST_BSY])
			sel_d = sel_data;
		if (cmd_wr && addressed)
			irq_d = 1'b0;
		unique case (state_q)
			IDC_IDLE:
			begin
				if (go && PACKET_DEV)
				begin
					err_d  = IDC_ERR_ABRT;
					sig_d  = {IDC_SIG_COUNT, IDC_SIG_LBA_LOW, IDC_SIG_LBA_MID, IDC_SIG_LBA_HIGH};
					stat_d = IDC_STATUS_RESET | 8'h01;
					irq_d  = !irq_disable;
				end
				else if (go)
				begin
					state_d = IDC_PREP;
					err_d   = 8'h00;
					stat_d  = 8'h80;
					idx_d   = 8'h00;
				end
			end
			IDC_PREP:
			begin
				if (prep_done)
				begin
					state_d = IDC_XFER;
					stat_d  = 8'h48;
					dout_d  = rom_word;
					irq_d   = !irq_disable;
				end
			end
			IDC_XFER:
			begin
				if (data_rd)
				begin
					irq_d = 1'b0;
					if (idx_q == IDC_LAST_WORD)
					begin
						state_d = IDC_IDLE;
						stat_d  = IDC_STATUS_RESET;
					end
					else
					begin
						idx_d  = idx_q + 8'h01;
						dout_d = rom_word;
					end
				end
			end
			default:
			begin
				state_d = IDC_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			state_q <= IDC_IDLE;
			idx_q   <= 8'h00;
			stat_q  <= IDC_STATUS_RESET;
			sel_q   <= IDC_SEL_RESET;
			err_q   <= 8'h00;
			sig_q   <= 32'h0000_0000;
			irq_q   <= 1'b0;
			dout_q  <= 16'h0000;
		end
		else
		begin
			state_q <= state_d;
			idx_q   <= idx_d;
			stat_q  <= stat_d;
			sel_q   <= sel_d;
			err_q   <= err_d;
			sig_q   <= sig_d;
			irq_q   <= irq_d;
			dout_q  <= dout_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign data_out     = dout_q;
	assign status       = stat_q;
	assign drive_select = sel_q;
	assign error_reg    = err_q;
	assign sig_count    = sig_q[31:24];
	assign sig_lba_low  = sig_q[23:16];
	assign sig_lba_mid  = sig_q[15:8];
	assign sig_lba_high = sig_q[7:0];
	assign intrq        = irq_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_done_status: assert property (@(posedge mclk) disable iff (reset)
		state_q == IDC_XFER && data_rd && idx_q == IDC_LAST_WORD |=> status == 8'h40)
		else $error("completion status wrong");
	a_prep_busy: assert property (@(posedge mclk) disable iff (reset)
		prep_start |=> status[IDC_ST_BSY] && !status[IDC_ST_DRQ])
		else $error("busy not set on command");
	a_drq_irq: assert property (@(posedge mclk) disable iff (reset)
		$rose(status[IDC_ST_DRQ]) |-> !status[IDC_ST_BSY] && (intrq == !$past(irq_disable)))
		else $error("drq or interrupt wrong");
	a_no_error: assert property (@(posedge mclk) disable iff (reset)
		!PACKET_DEV |-> !status[IDC_ST_ERR])
		else $error("error reported by non-packet device");
	a_packet_abort: assert property (@(posedge mclk) disable iff (reset)
		go && PACKET_DEV |=> error_reg == IDC_ERR_ABRT && sig_lba_high == IDC_SIG_LBA_HIGH)
		else $error("packet abort missing");
	a_word_zero: assert property (@(posedge mclk) disable iff (reset)
		state_q == IDC_XFER && idx_q == 8'h00 |-> !data_out[15] && data_out[7] == removable)
		else $error("word 0 wrong");
	a_word_cap2: assert property (@(posedge mclk) disable iff (reset)
		state_q == IDC_XFER && idx_q == IDC_W_CAP2 |-> data_out[15:14] == 2'b01 && data_out[0])
		else $error("word 50 wrong");
	a_sect_order: assert property (@(posedge mclk) disable iff (reset)
		state_q == IDC_XFER && idx_q == IDC_W_SECT_LO && data_rd |=> data_out == SECTORS[31:16])
		else $error("sector count order wrong");
	a_mult_word: assert property (@(posedge mclk) disable iff (reset)
		state_q == IDC_XFER && idx_q == IDC_W_MULTMAX |-> data_out[15:8] == IDC_MULT_MARK)
		else $error("word 47 wrong");
	a_feat_word: assert property (@(posedge mclk) disable iff (reset)
		state_q == IDC_XFER && idx_q == IDC_W_FEAT2 |-> data_out[15:14] == 2'b01)
		else $error("word 83 wrong");

endmodule
`default_nettype wire

/* core/idc_pkg.sv */
// Shared constants for the identification command block
// Assumes a single 10 MHz clock domain and a synchronous active-high reset
package idc_pkg;

	// ----------------------------------------
	// Command and status encoding
	// ----------------------------------------
	localparam logic [7:0] IDC_CMD_IDENTIFY  = 8'hec;
	localparam int         IDC_ST_BSY        = 7;
	localparam int         IDC_ST_DRDY       = 6;
	localparam int         IDC_ST_DF         = 5;
	localparam int         IDC_ST_DRQ        = 3;
	localparam int         IDC_ST_ERR        = 0;
	localparam int         IDC_DEV_BIT       = 4;
	localparam logic [7:0] IDC_ERR_ABRT      = 8'h04;
	localparam logic [7:0] IDC_STATUS_RESET  = 8'h40;
	localparam logic [7:0] IDC_SEL_RESET     = 8'h00;

	// ----------------------------------------
	// Packet-device signature
	// ----------------------------------------
	localparam logic [7:0] IDC_SIG_COUNT     = 8'h01;
	localparam logic [7:0] IDC_SIG_LBA_LOW   = 8'h01;
	localparam logic [7:0] IDC_SIG_LBA_MID   = 8'h14;
	localparam logic [7:0] IDC_SIG_LBA_HIGH  = 8'heb;

	// ----------------------------------------
	// Buffer layout
	// ----------------------------------------
	localparam int         IDC_WORDS         = 256;
	localparam logic [7:0] IDC_LAST_WORD     = 8'hff;
	localparam logic [7:0] IDC_W_GENCFG      = 8'h00;
	localparam logic [7:0] IDC_W_SERIAL_LO   = 8'h0a;
	localparam logic [7:0] IDC_W_SERIAL_HI   = 8'h13;
	localparam logic [7:0] IDC_W_FW_LO       = 8'h17;
	localparam logic [7:0] IDC_W_FW_HI       = 8'h1a;
	localparam logic [7:0] IDC_W_MODEL_LO    = 8'h1b;
	localparam logic [7:0] IDC_W_MODEL_HI    = 8'h2e;
	localparam logic [7:0] IDC_W_MULTMAX     = 8'h2f;
	localparam logic [7:0] IDC_W_CAP1        = 8'h31;
	localparam logic [7:0] IDC_W_CAP2        = 8'h32;
	localparam logic [7:0] IDC_W_VALID       = 8'h35;
	localparam logic [7:0] IDC_W_MULTCUR     = 8'h3b;
	localparam logic [7:0] IDC_W_SECT_LO     = 8'h3c;
	localparam logic [7:0] IDC_W_SECT_HI     = 8'h3d;
	localparam logic [7:0] IDC_W_MDMA        = 8'h3f;
	localparam logic [7:0] IDC_W_PIO         = 8'h40;
	localparam logic [7:0] IDC_W_MDMA_MIN    = 8'h41;
	localparam logic [7:0] IDC_W_MDMA_REC    = 8'h42;
	localparam logic [7:0] IDC_W_PIO_MIN     = 8'h43;
	localparam logic [7:0] IDC_W_PIO_IORDY   = 8'h44;
	localparam logic [7:0] IDC_W_QUEUE       = 8'h4b;
	localparam logic [7:0] IDC_W_MAJOR       = 8'h50;
	localparam logic [7:0] IDC_W_MINOR       = 8'h51;
	localparam logic [7:0] IDC_W_FEAT1       = 8'h52;
	localparam logic [7:0] IDC_W_FEAT2       = 8'h53;
	localparam logic [7:0] IDC_MULT_MARK     = 8'h80;
	localparam int         IDC_CAP2_ONE      = 14;
	localparam int         IDC_FEAT1_PKT     = 4;
	localparam int         IDC_FEAT2_ONE     = 14;
	localparam int         IDC_FEAT2_ZERO    = 15;
	localparam int         IDC_FEAT2_LBA48   = 10;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int         IDC_PREP_NS       = 1000;
	localparam int         IDC_CLK_NS        = 100;
	localparam int         IDC_PREP_CYC      = (IDC_PREP_NS + IDC_CLK_NS - 1) / IDC_CLK_NS;

	typedef enum logic [1:0] {
		IDC_IDLE = 2'b00,
		IDC_PREP = 2'b01,
		IDC_XFER = 2'b10
	} idc_state_t;

endpackage

/* core/idc_word_rom.sv */
// Identification word generator, one word per index
// Assumes strings arrive packed two characters per word, first character in the upper byte
`timescale 1ns/10ps
`default_nettype none
module idc_word_rom
	import idc_pkg::*;
#(
	parameter logic [159:0] SERIAL = {20{8'h20}},
	parameter logic [63:0]  FW_REV = {8{8'h20}},
	parameter logic [319:0] MODEL  = {40{8'h20}}
)
(
	input  wire logic [7:0]  index,
	input  wire logic        removable,
	input  wire logic        incomplete,
	input  wire logic [7:0]  mult_max,
	input  wire logic        mult_valid,
	input  wire logic [7:0]  mult_cur,
	input  wire logic [31:0] sectors,
	input  wire logic [2:0]  mdma_sel,
	input  wire logic [4:0]  queue_depth_m1,
	output logic      [15:0] word
);

	// ----------------------------------------
	// Word selection
	// ----------------------------------------
	always_comb
	begin
		word = 16'h0000;
		unique case (index)
			IDC_W_GENCFG:   word = {8'h00, removable, 4'h0, incomplete, 2'b00};
			IDC_W_MULTMAX:  word = {IDC_MULT_MARK, mult_max};
			IDC_W_CAP1:     word = 16'h2f00;
			IDC_W_CAP2:     word = 16'h4001;
			IDC_W_VALID:    word = 16'h0002;
			IDC_W_MULTCUR:  word = {7'h00, mult_valid, mult_cur};
			IDC_W_SECT_LO:  word = sectors[15:0];
			IDC_W_SECT_HI:  word = sectors[31:16];
			IDC_W_MDMA:     word = {5'h00, mdma_sel, 5'h00, 3'h7};
			IDC_W_PIO:      word = 16'h0003;
			IDC_W_MDMA_MIN: word = 16'h0078;
			IDC_W_MDMA_REC: word = 16'h0078;
			IDC_W_PIO_MIN:  word = 16'h0078;
			IDC_W_PIO_IORDY: word = 16'h0078;
			IDC_W_QUEUE:    word = {11'h000, queue_depth_m1};
			IDC_W_MAJOR:    word = 16'h00f0;
			IDC_W_MINOR:    word = 16'h0000;
			IDC_W_FEAT1:    word = 16'h0000;
			IDC_W_FEAT2:    word = 16'h4400;
			default:
			begin
				// Strings: low index carries the earliest characters
				if (index >= IDC_W_SERIAL_LO && index <= IDC_W_SERIAL_HI)
					word = SERIAL[159 - 16*(index - IDC_W_SERIAL_LO) -: 16];
				else if (index >= IDC_W_FW_LO && index <= IDC_W_FW_HI)
					word = FW_REV[63 - 16*(index - IDC_W_FW_LO) -: 16];
				else if (index >= IDC_W_MODEL_LO && index <= IDC_W_MODEL_HI)
					word = MODEL[319 - 16*(index - IDC_W_MODEL_LO) -: 16];
			end
		endcase
	end

endmodule
`default_nettype wire

/* core/idc_prep_timer.sv */
// Preparation delay counter
// Assumes start is a one-cycle pulse while idle
`timescale 1ns/10ps
`default_nettype none
module idc_prep_timer
	import idc_pkg::*;
#(
	parameter int CYCLES = IDC_PREP_CYC
)
(
	input  wire logic mclk,
	input  wire logic reset,
	input  wire logic start,
	output logic      done
);

	logic [15:0] cnt_q;
	logic [15:0] cnt_d;

	always_comb
	begin
		cnt_d = cnt_q;
		if (start)
			cnt_d = 16'(CYCLES);
		else if (cnt_q != 16'h0000)
			cnt_d = cnt_q - 16'h0001;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			cnt_q <= 16'h0000;
		else
			cnt_q <= cnt_d;
	end

	assign done = (cnt_q == 16'h0001);

endmodule
`default_nettype wire

/* tb/idc_host.sv */
// Host adapter model: drives the taskfile strobes one access at a time
// Assumes the bench calls its tasks one small step after a rising edge of mclk
`timescale 1ns/10ps
`default_nettype none
module idc_host
	import idc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic [7:0]  status,
	input  wire logic [15:0] data_out,
	output logic             cmd_wr,
	output logic      [7:0]  cmd_data,
	output logic             sel_wr,
	output logic      [7:0]  sel_data,
	output logic             data_rd
);
	initial
	begin
		cmd_wr   = 1'b0;
		cmd_data = 8'h00;
		sel_wr   = 1'b0;
		sel_data = 8'h00;
		data_rd  = 1'b0;
	end

	// ----------------------------------------
	// Register accesses
	// ----------------------------------------
	// One strobe cycle, then one idle cycle except in issue, so two strobes never share a time step
	task automatic select_dev(input logic dev);
	begin
		sel_data = {3'b000, dev, 4'h0};
		sel_wr   = 1'b1;
		@(posedge mclk);
		#1 sel_wr = 1'b0;
		sel_data = ~sel_data;
		@(posedge mclk) #1;
	end
	endtask

	task automatic issue(input logic [7:0] code);
		int i;
	begin
		for (i = 0; i < 64 && status[IDC_ST_DRDY] !== 1'b1; i++)
			@(posedge mclk) #1;
		cmd_data = code;
		cmd_wr   = 1'b1;
		@(posedge mclk);
		#1 cmd_wr = 1'b0;
		cmd_data = ~cmd_data;
	end
	endtask

	task automatic read_word(output logic [15:0] w);
	begin
		w       = data_out;
		data_rd = 1'b1;
		@(posedge mclk);
		#1 data_rd = 1'b0;
		@(posedge mclk) #1;
	end
	endtask
endmodule
`default_nettype wire

/* tb/idc_core_bench.sv */
// Bench for the identification engine: one plain device, one packet device
// Assumes both devices share the host strobes as on a two-device cable
`timescale 1ns/10ps
`default_nettype none
module idc_core_bench
	import idc_pkg::*;
;
	localparam int          PREP = 2;
	localparam logic [31:0] SECT = 32'h1234_5678;
	localparam logic [7:0]  MMAX = 8'h20;

	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic        irq_disable = 1'b0;
	logic        removable = 1'b0;
	logic        incomplete = 1'b0;
	logic        mult_valid = 1'b0;
	logic [7:0]  mult_cur = 8'h00;
	logic [2:0]  mdma_sel = 3'b000;
	logic [4:0]  queue_depth_m1 = 5'h00;
	logic        cmd_wr, sel_wr, data_rd, intrq;
	logic [7:0]  cmd_data, sel_data, status, drive_select, error_reg, p_status, p_err;
	logic [7:0]  sig [4];
	logic [7:0]  p_sig [4];
	logic [15:0] data_out;
	logic [15:0] buf_w [256];
	int          error_cnt = 0;
	int          n_checks = 0;

	always #50 mclk = ~mclk;

	idc_host i_host (.mclk(mclk), .status(status), .data_out(data_out), .cmd_wr(cmd_wr),
		.cmd_data(cmd_data), .sel_wr(sel_wr), .sel_data(sel_data), .data_rd(data_rd));

	idc_core #(.PREP_CYCLES(PREP), .SECTORS(SECT), .MULT_MAX(MMAX))
	i_dut (.mclk(mclk), .reset(reset), .cmd_wr(cmd_wr), .cmd_data(cmd_data), .sel_wr(sel_wr),
		.sel_data(sel_data), .irq_disable(irq_disable), .data_rd(data_rd), .removable(removable),
		.incomplete(incomplete), .mult_valid(mult_valid), .mult_cur(mult_cur), .mdma_sel(mdma_sel),
		.queue_depth_m1(queue_depth_m1), .data_out(data_out), .status(status), .drive_select(drive_select),
		.error_reg(error_reg), .sig_count(sig[0]), .sig_lba_low(sig[1]), .sig_lba_mid(sig[2]),
		.sig_lba_high(sig[3]), .intrq(intrq));

	// The packet device never starts its timer, so its preparation count is left at the default
	idc_core #(.DEVICE_NUM(1'b1), .PACKET_DEV(1'b1))
	i_pkt (.mclk(mclk), .reset(reset), .cmd_wr(cmd_wr), .cmd_data(cmd_data), .sel_wr(sel_wr),
		.sel_data(sel_data), .irq_disable(irq_disable), .data_rd(data_rd), .removable(removable),
		.incomplete(incomplete), .mult_valid(mult_valid), .mult_cur(mult_cur), .mdma_sel(mdma_sel),
		.queue_depth_m1(queue_depth_m1), .data_out(), .status(p_status), .drive_select(),
		.error_reg(p_err), .sig_count(p_sig[0]), .sig_lba_low(p_sig[1]), .sig_lba_mid(p_sig[2]),
		.sig_lba_high(p_sig[3]), .intrq());

	// ----------------------------------------
	// Checking and verdict
	// ----------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
	begin
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	end
	endtask

	task automatic tally_and_finish;
	begin
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Full 256-word read, one read strobe every other cycle; strings are left at their space default
	task automatic do_identify(input logic irqd, rem, inc, mv, input logic [7:0] mc,
		input logic [2:0] md, input logic [4:0] qd);
		int i;
	begin
		irq_disable    = irqd;
		removable      = rem;
		incomplete     = inc;
		mult_valid     = mv;
		mult_cur       = mc;
		mdma_sel       = md;
		queue_depth_m1 = qd;
		i_host.select_dev(1'b0);
		i_host.issue(IDC_CMD_IDENTIFY);
		check({8'h00, status}, 16'h0080, "busy");
		for (i = 0; i < 40 && status[IDC_ST_DRQ] !== 1'b1; i++)
			@(posedge mclk) #1;
		check({8'h00, status}, 16'h0048, "data ready");
		check({15'h0, intrq}, {15'h0, ~irqd}, "interrupt");
		for (i = 0; i < 256; i++)
		begin
			i_host.read_word(buf_w[i]);
			if (i == 0)
				check({15'h0, intrq}, 16'h0000, "interrupt cleared");
		end
		check({8'h00, status}, 16'h0040, "done status");
		check({8'h00, drive_select & 8'h10}, 16'h0000, "device echo");
		check({8'h00, error_reg}, 16'h0000, "no error");
		check(buf_w[0] & 16'h8084, {8'h00, rem, 4'h0, inc, 2'b00}, "word 0");
		for (i = 10; i < 47; i++)
			if (i < 20 || i > 22)
				check(buf_w[i], 16'h2020, "string");
		check(buf_w[47], {8'h80, MMAX}, "multiple max");
		check(buf_w[48], 16'h0000, "word 48");
		check(buf_w[49], 16'h2f00, "capabilities");
		check(buf_w[50] & 16'hc001, 16'h4001, "capabilities 2");
		check(buf_w[53] & 16'hfff8, 16'h0000, "validity");
		check(buf_w[59], {7'h00, mv, mc}, "multiple setting");
		check(buf_w[60], SECT[15:0], "sectors low");
		check(buf_w[61], SECT[31:16], "sectors high");
		check(buf_w[63] & 16'hffff, {5'h00, md, 8'h07}, "dma modes");
		check(buf_w[64] & 16'hff00, 16'h0000, "pio modes");
		check(buf_w[75], {11'h000, qd}, "queue depth");
		// Word 75 carries the queue depth and is checked on its own
		for (i = 69; i < 80; i++)
			if (i != 75)
				check(buf_w[i], 16'h0000, "reserved");
		check(buf_w[80] & 16'hff01, 16'h0000, "major version reserved");
		check(buf_w[82] & 16'h0010, 16'h0000, "packet bit");
		check(buf_w[83] & 16'hc000, 16'h4000, "feature marker");
		check({8'h00, sig[3]}, 16'h0000, "no packet signature");
	end
	endtask

	task automatic test_reset;
	begin
		check({8'h00, status}, {8'h00, IDC_STATUS_RESET}, "reset status");
		check({15'h0, intrq}, 16'h0000, "reset interrupt");
	end
	endtask

	task automatic test_refused;
	begin
		i_host.select_dev(1'b0);
		i_host.issue(8'hea);
		check({8'h00, status}, 16'h0040, "other code");
	end
	endtask

	task automatic test_packet;
		int i;
	begin
		i_host.select_dev(1'b1);
		check({8'h00, drive_select & 8'h10}, 16'h0010, "select readback");
		i_host.issue(IDC_CMD_IDENTIFY);
		check({8'h00, status}, 16'h0040, "unselected device");
		check({8'h00, p_status}, 16'h0041, "aborted status");
		check({8'h00, p_err}, {8'h00, IDC_ERR_ABRT}, "abort code");
		for (i = 0; i < 4; i++)
			check({8'h00, p_sig[i]}, {8'h00, i == 0 ? IDC_SIG_COUNT : i == 1 ? IDC_SIG_LBA_LOW :
				i == 2 ? IDC_SIG_LBA_MID : IDC_SIG_LBA_HIGH}, "signature");
	end
	endtask

	initial
	begin
		repeat (8) @(posedge mclk);
		#1 reset = 1'b0;
		test_reset();
		test_refused();
		test_packet();
		do_identify(1'b0, 1'b1, 1'b1, 1'b1, 8'h10, 3'b100, 5'h1f);
		do_identify(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 3'b001, 5'h00);
		tally_and_finish();
	end

	// Whole run is near 1050 cycles; the limit leaves ample room
	initial
	begin
		#(5000 * 100);
		error_cnt++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
